// file: hw/smr_defs.svh
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH

// Register offsets
`define SMR_REG_OVR_ADDR   8'h01
`define SMR_REG_SPD_ADDR   8'h0A
`define SMR_REG_STAT_ADDR  8'h0B

// Field positions in the override and mode register
`define SMR_OVR_BIT        0
`define SMR_PORT_BIT       1
`define SMR_PASS_BIT       2
`define SMR_MII_BIT        5

// Reset values
`define SMR_REG_OVR_RST    8'h00
`define SMR_REG_SPD_RST    8'h02

// Widths and timing counts
`define SMR_DATA_W         4
`define SMR_SYNC_W         6
`define SMR_CAP_WAIT       2'h2

`endif

// file: hw/smr_pkg.sv
package smr_pkg;

    // Transmission rate codes, high strap bit first
    typedef enum logic [1:0] {
        SMR_SPD_11M = 2'h0,
        SMR_SPD_9M  = 2'h1,
        SMR_SPD_4M  = 2'h2,
        SMR_SPD_3M  = 2'h3
    } smr_speed_type;

    // Strap capture sequence, one-hot
    typedef enum logic [1:0] {
        SMR_ST_SYNC = 2'b01,
        SMR_ST_RUN  = 2'b10
    } smr_state_type;

endpackage

// file: hw/smr_rx_strap_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "smr_defs.svh"

// Function
// - Valid high only while output data valid
// - Four data bits in MII, two in RMII
// - Speed straps sampled, honoured while override clear
// - Strap pair maps to 11/9/4/3 Mbps
// - Override set takes speed from transmission_speed_setting
// - Port strap latched: 0 PHY, 1 SoC
// - Override set takes port from register
// - Link indicator low while link connected
// - Link pin sampled: high MII, low RMII
// - Override set takes MII/RMII from bit 5
// - Transmit indicator low while transmit valid
// - Receive indicator low while receive valid
// - Host port active only when port selects SoC
// - Error low, passthrough copies PHY error
module smr_rx_strap_top (
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        rx_link_clk_in,
    input  wire logic        core_rx_valid_in,
    input  wire logic [3:0]  core_rx_data_in,
    output logic             core_rx_ready_out,
    output logic             host_rx_valid_out,
    output logic             host_rx_data_bit0_out,
    output logic             host_rx_data_bit1_out,
    output logic             host_rx_data_bit2_out,
    output logic             host_rx_data_bit3_out,
    output logic             host_rx_error_out,
    input  wire logic        phy_rx_error_in,
    input  wire logic        speed_strap_low_in,
    input  wire logic        speed_strap_high_in,
    input  wire logic        reserved_strap_in,
    input  wire logic        port_select_strap_in,
    input  wire logic        link_indicator_in,
    output logic             link_indicator_out,
    output logic             link_indicator_oe_out,
    input  wire logic        tx_activity_indicator_in,
    output logic             tx_activity_indicator_out,
    output logic             tx_activity_indicator_oe_out,
    input  wire logic        rx_activity_indicator_in,
    output logic             rx_activity_indicator_out,
    output logic             rx_activity_indicator_oe_out,
    input  wire logic        link_up_in,
    input  wire logic        tx_valid_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic [7:0]       reg_rdata_out,
    output smr_pkg::smr_speed_type speed_sel_out,
    output logic             host_port_sel_out,
    output logic             mii_mode_out
);
    smr_stream_if in_s ();
    smr_stream_if out_s ();

    logic [`SMR_SYNC_W-1:0] meta_q, sync_q;
    logic                   clk_prev_q;
    logic                   link_rise;
    smr_pkg::smr_state_type st_q, st_d;
    logic [1:0]             cap_cnt_q, cap_cnt_d;
    smr_pkg::smr_speed_type strap_spd_q, strap_spd_d;
    logic                   strap_port_q, strap_port_d;
    logic                   strap_mii_q, strap_mii_d;
    logic [7:0]             reg_ovr_q, reg_ovr_d, reg_spd_q, reg_spd_d;
    logic [7:0]             rdata_q, rdata_d;
    logic                   valid_q, valid_d, err_q, err_d;
    logic [3:0]             data_q, data_d;
    logic                   lnk_led_q, lnk_led_d, tx_led_q, tx_led_d, rx_led_q, rx_led_d;
    logic                   run, ovr, pass, active;

    // Pins pass two flops; order: link clock, error, speed low, speed high, port, link pin
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_q     <= 6'h00;
            sync_q     <= 6'h00;
            clk_prev_q <= 1'b0;
        end else begin
            meta_q     <= {rx_link_clk_in, phy_rx_error_in, speed_strap_low_in,
                           speed_strap_high_in, port_select_strap_in, link_indicator_in};
            sync_q     <= meta_q;
            clk_prev_q <= sync_q[5];
        end
    end

    assign link_rise = sync_q[5] & ~clk_prev_q;
    assign run       = (st_q == smr_pkg::SMR_ST_RUN);
    assign ovr       = reg_ovr_q[`SMR_OVR_BIT];
    assign pass      = reg_ovr_q[`SMR_PASS_BIT];

    // Effective configuration: straps unless overridden
    assign speed_sel_out     = ovr ? smr_pkg::smr_speed_type'(reg_spd_q[1:0])
                                   : strap_spd_q;
    assign host_port_sel_out = ovr ? reg_ovr_q[`SMR_PORT_BIT] : strap_port_q;
    assign mii_mode_out      = ovr ? reg_ovr_q[`SMR_MII_BIT] : strap_mii_q;
    assign active            = run & host_port_sel_out;

    // Strap capture once synchronisers have filled after reset release
    always_comb begin
        st_d         = st_q;
        cap_cnt_d    = cap_cnt_q;
        strap_spd_d  = strap_spd_q;
        strap_port_d = strap_port_q;
        strap_mii_d  = strap_mii_q;
        unique case (st_q)
            smr_pkg::SMR_ST_SYNC: begin
                cap_cnt_d = cap_cnt_q + 2'h1;
                if (cap_cnt_q == `SMR_CAP_WAIT) begin
                    st_d         = smr_pkg::SMR_ST_RUN;
                    strap_spd_d  = smr_pkg::smr_speed_type'({sync_q[2], sync_q[3]});
                    strap_port_d = sync_q[1];
                    strap_mii_d  = sync_q[0];
                end
            end
            smr_pkg::SMR_ST_RUN: begin
                st_d = smr_pkg::SMR_ST_RUN;
            end
            default: begin
                st_d = smr_pkg::SMR_ST_SYNC;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q         <= smr_pkg::SMR_ST_SYNC;
            cap_cnt_q    <= 2'h0;
            strap_spd_q  <= smr_pkg::SMR_SPD_11M;
            strap_port_q <= 1'b0;
            strap_mii_q  <= 1'b1;
        end else begin
            st_q         <= st_d;
            cap_cnt_q    <= cap_cnt_d;
            strap_spd_q  <= strap_spd_d;
            strap_port_q <= strap_port_d;
            strap_mii_q  <= strap_mii_d;
        end
    end

    // Register writes and registered reads; unmapped reads return zero
    always_comb begin
        reg_ovr_d = reg_ovr_q;
        reg_spd_d = reg_spd_q;
        rdata_d   = rdata_q;
        if (reg_wr_in && reg_addr_in == `SMR_REG_OVR_ADDR) begin
            reg_ovr_d = reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == `SMR_REG_SPD_ADDR) begin
            reg_spd_d = reg_wdata_in;
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `SMR_REG_OVR_ADDR:  rdata_d = reg_ovr_q;
                `SMR_REG_SPD_ADDR:  rdata_d = reg_spd_q;
                `SMR_REG_STAT_ADDR: rdata_d = {3'h0, run, mii_mode_out,
                                               host_port_sel_out, speed_sel_out};
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_ovr_q <= `SMR_REG_OVR_RST;
            reg_spd_q <= `SMR_REG_SPD_RST;
            rdata_q   <= 8'h00;
        end else begin
            reg_ovr_q <= reg_ovr_d;
            reg_spd_q <= reg_spd_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    // Core stream enters the two-entry buffer; receiver stall backs up to the source
    assign in_s.valid        = core_rx_valid_in;
    assign in_s.data         = core_rx_data_in;
    assign core_rx_ready_out = in_s.ready;
    assign out_s.ready       = link_rise & active;

    smr_skid_buf u_buf (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .fill_in     (in_s),
        .drain_out   (out_s)
    );

    // Host receive port updates on each link clock rise; link and transmit indicators update every core clock
    always_comb begin
        valid_d   = valid_q;
        data_d    = mii_mode_out ? data_q : {2'h0, data_q[1:0]};
        rx_led_d  = rx_led_q;
        err_d     = pass & sync_q[4];
        lnk_led_d = ~link_up_in;
        tx_led_d  = ~tx_valid_in;
        if (!active) begin
            valid_d = 1'b0;
            data_d  = 4'h0;
        end else if (link_rise) begin
            valid_d = out_s.valid;
            data_d  = !out_s.valid ? 4'h0 :
                      mii_mode_out ? out_s.data : {2'h0, out_s.data[1:0]};
        end
        rx_led_d = ~valid_d;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            valid_q   <= 1'b0;
            data_q    <= 4'h0;
            err_q     <= 1'b0;
            lnk_led_q <= 1'b1;
            tx_led_q  <= 1'b1;
            rx_led_q  <= 1'b1;
        end else begin
            valid_q   <= valid_d;
            data_q    <= data_d;
            err_q     <= err_d;
            lnk_led_q <= lnk_led_d;
            tx_led_q  <= tx_led_d;
            rx_led_q  <= rx_led_d;
        end
    end

    assign host_rx_valid_out            = valid_q;
    assign host_rx_data_bit0_out        = data_q[0];
    assign host_rx_data_bit1_out        = data_q[1];
    assign host_rx_data_bit2_out        = data_q[2];
    assign host_rx_data_bit3_out        = data_q[3];
    assign host_rx_error_out            = err_q;
    assign link_indicator_out           = lnk_led_q;
    assign tx_activity_indicator_out    = tx_led_q;
    assign rx_activity_indicator_out    = rx_led_q;
    // Indicator pins stay inputs until the straps are captured
    assign link_indicator_oe_out        = run;
    assign tx_activity_indicator_oe_out = run;
    assign rx_activity_indicator_oe_out = run;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_pop;
        link_rise && out_s.ready && out_s.valid;
    endsequence
    property p_pop_shows;
        s_pop |=> host_rx_valid_out ##1 $stable(host_rx_valid_out);
    endproperty
    a_pop_shows: assert property (p_pop_shows) else $error("popped word not shown");
    property p_valid_moves_on_edge;
        $rose(host_rx_valid_out) |-> $past(link_rise);
    endproperty
    a_valid_moves_on_edge: assert property (p_valid_moves_on_edge) else $error("valid off edge");
    property p_rmii_upper_zero;
        !mii_mode_out |=> !host_rx_data_bit2_out && !host_rx_data_bit3_out;
    endproperty
    a_rmii_upper_zero: assert property (p_rmii_upper_zero) else $error("RMII upper bits set");
    property p_speed_strap;
        run && !ovr |-> speed_sel_out == strap_spd_q;
    endproperty
    a_speed_strap: assert property (p_speed_strap) else $error("strap speed not used");
    property p_speed_override;
        ovr |-> speed_sel_out[1:0] == reg_spd_q[1:0];
    endproperty
    a_speed_override: assert property (p_speed_override) else $error("override speed not used");
    property p_host_idle;
        !active |=> !host_rx_valid_out;
    endproperty
    a_host_idle: assert property (p_host_idle) else $error("host port drove while inactive");
    property p_strap_hold;
        run |=> $stable(strap_spd_q) && $stable(strap_mii_q) && $stable(strap_port_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");
    property p_oe_late;
        !run |-> !link_indicator_oe_out && !rx_activity_indicator_oe_out;
    endproperty
    a_oe_late: assert property (p_oe_late) else $error("indicator driven before capture");
    property p_link_led;
        link_up_in |=> !link_indicator_out;
    endproperty
    a_link_led: assert property (p_link_led) else $error("link indicator wrong");
    property p_rx_led;
        rx_activity_indicator_out == !host_rx_valid_out;
    endproperty
    a_rx_led: assert property (p_rx_led) else $error("rx indicator wrong");
    property p_err_normal;
        !pass |=> !host_rx_error_out;
    endproperty
    a_err_normal: assert property (p_err_normal) else $error("error driven outside passthrough");
endmodule

`default_nettype wire

// file: hw/smr_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
`include "smr_defs.svh"

module smr_skid_buf (
    input  wire logic   core_clk_in,
    input  wire logic   sys_rst_in,
    smr_stream_if.snk   fill_in,
    smr_stream_if.src   drain_out
);
    logic [`SMR_DATA_W-1:0] mem_q [2];
    logic [`SMR_DATA_W-1:0] mem_d [2];
    logic                   wr_q, wr_d, rd_q, rd_d;
    logic [1:0]             cnt_q, cnt_d;
    logic                   push, pop;

    // Handshakes follow the fill count
    assign fill_in.ready   = (cnt_q != 2'h2);
    assign drain_out.valid = (cnt_q != 2'h0);
    assign drain_out.data  = mem_q[rd_q];
    assign push            = fill_in.valid & fill_in.ready;
    assign pop             = drain_out.valid & drain_out.ready;

    // Next pointer, count and storage
    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q ^ push;
        rd_d  = rd_q ^ pop;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        if (push) begin
            mem_d[wr_q] = fill_in.data;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_q[0] <= 4'h0;
            mem_q[1] <= 4'h0;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    property p_no_overflow;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        cnt_q == 2'h2 |-> !fill_in.ready ##1 cnt_q != 2'h3;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("buffer overfilled");

endmodule

`default_nettype wire

// file: hw/smr_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "smr_defs.svh"

interface smr_stream_if;
    logic                   valid;
    logic                   ready;
    logic [`SMR_DATA_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// file: testbench/smr_mac_model.sv
`timescale 1ns/1ps
`default_nettype none

module smr_mac_model (
    input  wire logic       run_in,
    input  wire logic       rx_valid_in,
    input  wire logic [3:0] rx_data_in,
    output logic            rx_clk_out
);
    logic [3:0] got [$];

    // Receive clock runs only inside frames and rests low between them
    initial begin
        rx_clk_out = 1'b0;
        #37;
        forever begin
            if (run_in) begin
                rx_clk_out = 1'b1;
                #80;
                rx_clk_out = 1'b0;
                #80;
            end else begin
                #10;
            end
        end
    end

    // Nibble of the previous period is taken at each rise while valid
    always @(posedge rx_clk_out) begin
        if (rx_valid_in === 1'b1) begin
            got.push_back(rx_data_in);
        end
    end
endmodule

`default_nettype wire

// file: testbench/smr_rx_strap_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module smr_rx_strap_top_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       cv = 1'b0;
    logic [3:0] cd = 4'h0;
    logic       spd_lo = 1'b0;
    logic       spd_hi = 1'b1;
    logic       port_strap = 1'b1;
    logic       link_strap = 1'b1;
    logic       perr = 1'b0;
    logic       lup = 1'b0;
    logic       txv = 1'b0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic       run = 1'b0;
    logic [7:0] rv;
    int         err_total = 0;
    int         num_checks = 0;
    wire logic       lclk;
    wire logic       rdy;
    wire logic       hv;
    wire logic [3:0] hd;
    wire logic       herr;
    wire logic       l_o;
    wire logic       l_oe;
    wire logic       t_o;
    wire logic       t_oe;
    wire logic       r_o;
    wire logic       r_oe;
    wire logic [7:0] rdata;
    wire logic [1:0] spd;
    wire logic       psel;
    wire logic       mii;
    // Pin levels: device drive, else board strap or pull-up
    wire logic l_pin = l_oe ? l_o : link_strap;
    wire logic t_pin = t_oe ? t_o : 1'b1;
    wire logic r_pin = r_oe ? r_o : 1'b1;

    always #10 clk = ~clk;

    smr_rx_strap_top smr_rx_strap_top_inst (
        .core_clk_in(clk), .sys_rst_in(rst), .rx_link_clk_in(lclk),
        .core_rx_valid_in(cv), .core_rx_data_in(cd), .core_rx_ready_out(rdy),
        .host_rx_valid_out(hv), .host_rx_data_bit0_out(hd[0]),
        .host_rx_data_bit1_out(hd[1]), .host_rx_data_bit2_out(hd[2]),
        .host_rx_data_bit3_out(hd[3]), .host_rx_error_out(herr),
        .phy_rx_error_in(perr), .speed_strap_low_in(spd_lo),
        .speed_strap_high_in(spd_hi), .reserved_strap_in(1'b1),
        .port_select_strap_in(port_strap), .link_indicator_in(l_pin),
        .link_indicator_out(l_o), .link_indicator_oe_out(l_oe),
        .tx_activity_indicator_in(t_pin), .tx_activity_indicator_out(t_o),
        .tx_activity_indicator_oe_out(t_oe), .rx_activity_indicator_in(r_pin),
        .rx_activity_indicator_out(r_o), .rx_activity_indicator_oe_out(r_oe),
        .link_up_in(lup), .tx_valid_in(txv), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
        .speed_sel_out(spd), .host_port_sel_out(psel), .mii_mode_out(mii)
    );

    smr_mac_model smr_mac_model_inst (
        .run_in(run), .rx_valid_in(hv), .rx_data_in(hd), .rx_clk_out(lclk)
    );

    task automatic end_sim();
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wd = d;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        rd = 1'b1;
        addr = a;
        tick(1);
        d = rdata;
        rd = 1'b0;
        tick(1);
    endtask

    // Straps given as {link pin, port, speed high, speed low}
    task automatic do_reset(input logic [3:0] s);
        rst = 1'b1;
        {link_strap, port_strap, spd_hi, spd_lo} = s;
        tick(16);
        rst = 1'b0;
        tick(5);
    endtask

    // Core word held until the buffer accepts it
    task automatic push(input logic [3:0] d);
        cv = 1'b1;
        cd = d;
        for (int k = 0; k < 400 && rdy !== 1'b1; k++) tick(1);
        tick(1);
        cv = 1'b0;
        tick(1);
    endtask

    // One frame of link clock, then the nibbles seen by the far side
    task automatic frame(input int n, input logic [15:0] e);
        run = 1'b1;
        tick(80);
        run = 1'b0;
        tick(12);
        chk(8'(n), 8'(smr_mac_model_inst.got.size()));
        for (int k = 0; k < n && k < smr_mac_model_inst.got.size(); k++)
            chk({4'h0, e[4*k+:4]}, {4'h0, smr_mac_model_inst.got[k]});
        smr_mac_model_inst.got.delete();
        chk(8'h00, {7'h0, hv});
        chk(8'h01, {7'h0, r_pin});
    endtask

    initial begin
        #400_000;
        err_total++;
        end_sim();
    end

    initial begin
        #1;
        do_reset(4'b1110);
        rreg(8'h01, rv);
        chk(8'h00, rv);
        rreg(8'h0A, rv);
        chk(8'h02, rv);
        rreg(8'h33, rv);
        chk(8'h00, rv);
        wreg(8'h0B, 8'hFF);
        rreg(8'h0B, rv);
        chk(8'h1E, rv);
        // Every strap code, port and interface mode; speed and port held after capture
        for (int i = 0; i < 4; i++) begin
            do_reset({i[1], i[0], i[1], i[0]});
            chk(8'(i), {6'h0, spd});
            chk({7'h0, i[0]}, {7'h0, psel});
            chk({7'h0, i[1]}, {7'h0, mii});
            spd_lo = ~spd_lo;
            port_strap = ~port_strap;
            tick(4);
            chk(8'(i), {6'h0, spd});
            chk({7'h0, i[0]}, {7'h0, psel});
            chk(8'h07, {5'h0, l_oe, t_oe, r_oe});
        end
        // Register override of speed, port and mode
        for (int i = 0; i < 4; i++) begin
            wreg(8'h0A, 8'(i));
            wreg(8'h01, {2'h0, i[1], 3'h0, i[0], 1'b1});
            chk(8'(i), {6'h0, spd});
            chk({7'h0, i[0]}, {7'h0, psel});
            chk({7'h0, i[1]}, {7'h0, mii});
            rreg(8'h0A, rv);
            chk(8'(i), rv);
        end
        // Indicators follow link and transmit activity
        lup = 1'b1;
        txv = 1'b1;
        tick(3);
        chk(8'h00, {6'h0, l_pin, t_pin});
        lup = 1'b0;
        txv = 1'b0;
        tick(3);
        chk(8'h03, {6'h0, l_pin, t_pin});
        // Passthrough copies the far-port error
        perr = 1'b1;
        wreg(8'h01, 8'h05);
        tick(4);
        chk(8'h01, {7'h0, herr});
        wreg(8'h01, 8'h01);
        tick(4);
        chk(8'h00, {7'h0, herr});
        perr = 1'b0;
        // MII stream, buffer full while the link clock rests
        do_reset(4'b1110);
        push(4'hA);
        push(4'h5);
        chk(8'h00, {7'h0, rdy});
        run = 1'b1;
        push(4'hC);
        frame(3, 16'h0C5A);
        // RMII carries only the two low bits
        wreg(8'h01, 8'h03);
        push(4'hF);
        push(4'h6);
        frame(2, 16'h0023);
        // Port toward the PHY keeps the host side silent
        wreg(8'h01, 8'h21);
        push(4'h9);
        frame(0, 16'h0000);
        end_sim();
    end
endmodule

`default_nettype wire
